/* bench/pfs_board_model.sv */
// Purpose: board side of the straps, weak pulldowns plus fitted pullups
// Assumes: pull_up_in bit set means an external pullup is fitted
// Notes: bit order follows pfs_straps_s, width_hi first
`timescale 1ns/10ps
`default_nettype none
module pfs_board_model (
   input  wire logic [4:0]           pull_up_in,
   output var pfs_pkg::pfs_straps_s  straps_out
);
   // unfitted straps fall to the pulldown level
   assign straps_out = pfs_pkg::pfs_straps_s'(pull_up_in & 5'h1f);
endmodule : pfs_board_model
`default_nettype wire

/* bench/pin_function_select_and_boot_straps_tb.sv */
// Purpose: self-checking bench for the pin-function select block
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes: expectations come from a bench model of straps and firmware state
`timescale 1ns/10ps
`default_nettype none
module pin_function_select_and_boot_straps_tb;
   logic clk_in, sys_rst_in, clk_en_in, fw_width_wr_in, fw_steer_wr_in, fw_steer_in;
   logic [4:0] pull_up;
   pfs_pkg::pfs_straps_s straps_in;
   pfs_pkg::pfs_width_e fw_width_in, boot_width_out, m_w;
   logic [7:0] cfg_idx39_in, cfg_idx38_in, cfg_idxdd_in;
   pfs_pkg::pfs_card_s sockb_card_in, socka_card_in;
   pfs_pkg::pfs_pwr_s socka_pwr_in, sockb_pwr_in;
   logic [8:0] gpio_out_in, gpio_oe_in;
   logic [5:0] printer_out_in, printer_oe_in, grp_b_pad_in, grp_b_pad_out, grp_b_pad_oe_out;
   logic [5:0] grp_pwr_pad_out, grp_pwr_pad_oe_out;
   logic [13:0] lcd_sig_in, vlbus_out_in, vlbus_oe_in, grp_lcd_pad_out, grp_lcd_pad_oe_out;
   logic test_data_out_in, burst_last_in, sys_clk_copy_in, boot_decode_in, rom_select_any_in;
   logic rom_is_32_in, databuf_oe_in, databuf_rdl_in, databuf_rdh_in, clk_pad_in;
   logic [3:0] grp_a_pad_in, grp_a_pad_out, grp_a_pad_oe_out, test_port_out;
   logic clk_pad_out, clk_pad_oe_out, timer_clk_out, timer_clk_sel_out, boot_rom_select_out;
   logic socka_boot_sel_out, rom32_buffer_oe_out, databuf_output_en_out, databuf_read_low_out;
   logic databuf_read_high_out, boot_steer_out, rom32_allowed_out;
   logic m_st, m_ok, m_ts, m_buf;
   int   errors, checks_done, seed, i;

   pfs_board_model BOARD (.pull_up_in(pull_up), .straps_out(straps_in));
   pfs_pin_mux DUT (.clk_in, .sys_rst_in, .clk_en_in, .straps_in, .cfg_idx39_in, .cfg_idx38_in,
      .cfg_idxdd_in, .fw_width_wr_in, .fw_width_in, .fw_steer_wr_in, .fw_steer_in,
      .sockb_card_in, .socka_card_in, .socka_pwr_in, .sockb_pwr_in, .gpio_out_in, .gpio_oe_in,
      .printer_out_in, .printer_oe_in, .lcd_sig_in, .vlbus_out_in, .vlbus_oe_in,
      .test_data_out_in, .burst_last_in, .sys_clk_copy_in, .boot_decode_in,
      .rom_select_any_in, .rom_is_32_in, .databuf_oe_in, .databuf_rdl_in, .databuf_rdh_in,
      .grp_b_pad_in, .grp_b_pad_out, .grp_b_pad_oe_out, .grp_pwr_pad_out, .grp_pwr_pad_oe_out,
      .grp_a_pad_in, .grp_a_pad_out, .grp_a_pad_oe_out, .grp_lcd_pad_out, .grp_lcd_pad_oe_out,
      .clk_pad_in, .clk_pad_out, .clk_pad_oe_out, .timer_clk_out, .timer_clk_sel_out,
      .test_port_out, .boot_rom_select_out, .socka_boot_sel_out, .rom32_buffer_oe_out,
      .databuf_output_en_out, .databuf_read_low_out, .databuf_read_high_out,
      .boot_width_out, .boot_steer_out, .rom32_allowed_out);

   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task wrap_up;
      if (errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   task cmp(input logic [15:0] g, input logic [15:0] e, input string m);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : cmp

   task drive(input logic [159:0] r);
      {sockb_card_in, socka_card_in, socka_pwr_in, sockb_pwr_in, gpio_out_in, gpio_oe_in,
       printer_out_in, printer_oe_in, lcd_sig_in, vlbus_out_in, vlbus_oe_in, cfg_idx39_in,
       cfg_idx38_in, cfg_idxdd_in, test_data_out_in, burst_last_in, sys_clk_copy_in,
       boot_decode_in, rom_select_any_in, rom_is_32_in, databuf_oe_in, databuf_rdl_in,
       databuf_rdh_in, grp_b_pad_in, grp_a_pad_in, clk_pad_in} <= r[133:0];
   endtask : drive

   task chk;
      logic sb, ko, rd;
      logic [1:0] k;
      @(posedge clk_in);
      drive({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
      @(negedge clk_in);
      sb = (cfg_idx39_in[1:0] === pfs_pkg::SOCKB_SEL_ON);
      cmp(grp_b_pad_out, sb ? {sockb_card_in.ce_low, sockb_card_in.ce_high, 1'b0,
          sockb_card_in.reg_sel, sockb_card_in.card_reset, 1'b0} : printer_out_in, "b");
      cmp(grp_b_pad_oe_out, sb ? 6'h36 : printer_oe_in, "b oe");
      cmp(grp_pwr_pad_out, {cfg_idx39_in[pfs_pkg::SOCKB_PWR_BIT] ? sockb_pwr_in : gpio_out_in[5:3],
          cfg_idx39_in[pfs_pkg::SOCKA_PWR_BIT] ? socka_pwr_in : gpio_out_in[2:0]}, "pwr");
      cmp(grp_pwr_pad_oe_out, {cfg_idx39_in[pfs_pkg::SOCKB_PWR_BIT] ? 3'h7 : gpio_oe_in[5:3],
          cfg_idx39_in[pfs_pkg::SOCKA_PWR_BIT] ? 3'h7 : gpio_oe_in[2:0]}, "pwr oe");
      cmp(grp_lcd_pad_out, cfg_idxdd_in[pfs_pkg::GFX_EN_BIT] ? lcd_sig_in : vlbus_out_in, "lcd");
      cmp(grp_lcd_pad_oe_out, cfg_idxdd_in[pfs_pkg::GFX_EN_BIT] ? 14'h3fff : vlbus_oe_in, "lcd oe");
      k = cfg_idx38_in[7:6];
      ko = (k === pfs_pkg::CLKPIN_BURST) || (k === pfs_pkg::CLKPIN_CLKOUT);
      cmp({clk_pad_oe_out, timer_clk_sel_out, timer_clk_out},
          {ko, k === pfs_pkg::CLKPIN_TMRIN, clk_pad_in & (k === pfs_pkg::CLKPIN_TMRIN)}, "clk");
      if (ko) cmp(clk_pad_out, (k === pfs_pkg::CLKPIN_BURST) ? burst_last_in : sys_clk_copy_in, "clk o");
      else cmp(clk_pad_out, 1'b0, "clk idle");
      rd = m_st & boot_decode_in;
      cmp(grp_a_pad_out, m_ts ? {3'h0, test_data_out_in} : {socka_card_in.ce_low | rd,
          socka_card_in.ce_high | rd, socka_card_in.card_reset, socka_card_in.reg_sel}, "a");
      cmp({grp_a_pad_oe_out, test_port_out}, m_ts ? {4'h1, grp_a_pad_in[3:1], test_data_out_in}
          : 8'hf0, "a oe");
      cmp({boot_rom_select_out, socka_boot_sel_out},
          {boot_decode_in & ~m_st, boot_decode_in & m_st}, "steer");
      cmp(rom32_buffer_oe_out, m_ok & rom_select_any_in & rom_is_32_in, "r32");
      cmp({databuf_output_en_out, databuf_read_low_out, databuf_read_high_out},
          {3{m_buf}} & {databuf_oe_in, databuf_rdl_in, databuf_rdh_in}, "dbuf");
      cmp({boot_width_out, boot_steer_out, rom32_allowed_out}, {m_w, m_st, m_ok}, "held");
   endtask : chk

   task do_reset(input logic [4:0] pu);
      logic [1:0] c;
      @(posedge clk_in);
      pull_up <= pu;
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      fw_width_wr_in <= 1'b1;
      fw_width_in <= pfs_pkg::PFS_W16;
      fw_steer_wr_in <= 1'b1;
      fw_steer_in <= ~pu[2];
      @(posedge clk_in);
      fw_width_wr_in <= 1'b0;
      fw_steer_wr_in <= 1'b0;
      pull_up <= ~pu;
      c = pu[4:3];
      m_w = (c == pfs_pkg::WID_X8) ? pfs_pkg::PFS_W8 : (c == pfs_pkg::WID_X16) ? pfs_pkg::PFS_W16
          : (c == pfs_pkg::WID_X32) ? pfs_pkg::PFS_W32 : pfs_pkg::PFS_WRSVD;
      {m_ok, m_st, m_buf, m_ts} = {c == pfs_pkg::WID_X32, pu[2], pu[1], pu[0]};
   endtask : do_reset

   task fw(input pfs_pkg::pfs_width_e w, input logic s, input logic en);
      @(posedge clk_in);
      {clk_en_in, fw_width_wr_in, fw_steer_wr_in, fw_width_in, fw_steer_in} <= {en, 2'h3, w, s};
      @(posedge clk_in);
      {clk_en_in, fw_width_wr_in, fw_steer_wr_in} <= 3'h4;
      if (en) {m_w, m_st} = {w, s};
      repeat (2) chk();
   endtask : fw

   initial begin
      seed = 32'h1ed3;
      {errors, checks_done} = '0;
      {sys_rst_in, clk_en_in, pull_up, fw_width_wr_in, fw_steer_wr_in, fw_steer_in} = 10'h300;
      fw_width_in = pfs_pkg::PFS_W8;
      drive('0);
      repeat (6) @(posedge clk_in);
      for (i = 0; i < 32; i++) begin
         if (i[4:2] != 3'h7) begin
            do_reset(i[4:0]);
            repeat (12) chk();
         end
      end
      do_reset(5'h18);
      for (i = 0; i < 4; i++) fw(pfs_pkg::pfs_width_e'(i[1:0]), i[0], 1'b1);
      fw(pfs_pkg::PFS_W32, 1'b0, 1'b0);
      fw(pfs_pkg::PFS_W16, 1'b1, 1'b1);
      wrap_up();
   end

   initial begin
      #200000;
      errors++;
      wrap_up();
   end
endmodule : pin_function_select_and_boot_straps_tb
`default_nettype wire

/* core/pfs_pin_mux.sv */
// Purpose: pin-function multiplexing and reset strap decode
// Assumes: config bits are plain inputs; straps are 0 unless pulled high
// Notes: multiplexed pins are out and enable signals; only socket B, socket A and clock pins also have an in
// Notes on behaviour
// - index 39h[1:0]=01 puts socket B card controls on gpio/printer pins
// - index 39h[5] puts socket A supply/program controls on three gpio pins
// - index 39h[6] puts socket B supply/program controls on three gpio pins
// - test strap low: socket A controls; high: test clock/mode/data pins
// - index ddh[2] swaps local-bus pins for lcd panel signals
// - index 38h[7:6]: 01 burst last, 10 clock out, 11 timer clock in
// - straps only fix reset-time functions; the rest come from config bits
// - unpulled strap reads 0 and selects the default function
// - width straps: 00 x8, 10 x16, 11 x32, 01 reserved
// - 32-bit rom buffer enable only with x32 strap, on 32-bit rom accesses
// - data-bus buffer controls enabled solely by buffer strap
// - firmware may override strapped boot rom width
// - steering strap routes boot decode to own pin or socket A selects
// - steering 0 own pin, 1 socket A
// - socket A keeps normal operation while redirected
// - firmware may enable or disable the redirection any time except during reset and the first cycle after it
`timescale 1ns/10ps
`default_nettype none
module pfs_pin_mux (
   input  wire logic               clk_in,
   input  wire logic               sys_rst_in,
   input  wire logic               clk_en_in,
   // straps
   input  wire pfs_pkg::pfs_straps_s straps_in,
   // config index contents
   input  wire logic [7:0]         cfg_idx39_in,
   input  wire logic [7:0]         cfg_idx38_in,
   input  wire logic [7:0]         cfg_idxdd_in,
   input  wire logic               fw_width_wr_in,
   input  wire pfs_pkg::pfs_width_e fw_width_in,
   input  wire logic               fw_steer_wr_in,
   input  wire logic               fw_steer_in,
   // internal sources
   input  wire pfs_pkg::pfs_card_s sockb_card_in,
   input  wire pfs_pkg::pfs_card_s socka_card_in,
   input  wire pfs_pkg::pfs_pwr_s  socka_pwr_in,
   input  wire pfs_pkg::pfs_pwr_s  sockb_pwr_in,
   input  wire logic [8:0]         gpio_out_in,
   input  wire logic [8:0]         gpio_oe_in,
   input  wire logic [5:0]         printer_out_in,
   input  wire logic [5:0]         printer_oe_in,
   input  wire logic [13:0]        lcd_sig_in,
   input  wire logic [13:0]        vlbus_out_in,
   input  wire logic [13:0]        vlbus_oe_in,
   input  wire logic               test_data_out_in,
   input  wire logic               burst_last_in,
   input  wire logic               sys_clk_copy_in,
   input  wire logic               boot_decode_in,
   input  wire logic               rom_select_any_in,
   input  wire logic               rom_is_32_in,
   input  wire logic               databuf_oe_in,
   input  wire logic               databuf_rdl_in,
   input  wire logic               databuf_rdh_in,
   // pad groups
   input  wire logic [5:0]         grp_b_pad_in,
   output logic [5:0]              grp_b_pad_out,
   output logic [5:0]              grp_b_pad_oe_out,
   output logic [5:0]              grp_pwr_pad_out,
   output logic [5:0]              grp_pwr_pad_oe_out,
   input  wire logic [3:0]         grp_a_pad_in,
   output logic [3:0]              grp_a_pad_out,
   output logic [3:0]              grp_a_pad_oe_out,
   output logic [13:0]             grp_lcd_pad_out,
   output logic [13:0]             grp_lcd_pad_oe_out,
   input  wire logic               clk_pad_in,
   output logic                    clk_pad_out,
   output logic                    clk_pad_oe_out,
   output logic                    timer_clk_out,
   output logic                    timer_clk_sel_out,
   output logic [3:0]              test_port_out,
   output logic                    boot_rom_select_out,
   output logic                    socka_boot_sel_out,
   output logic                    rom32_buffer_oe_out,
   output logic                    databuf_output_en_out,
   output logic                    databuf_read_low_out,
   output logic                    databuf_read_high_out,
   output var pfs_pkg::pfs_width_e boot_width_out,
   output logic                    boot_steer_out,
   output logic                    rom32_allowed_out
);
   typedef struct packed {
      pfs_pkg::pfs_width_e width;
      logic                steer;
      logic                rom32_ok;
      logic                rst_seen;    // reset high on the last enabled edge
   } pfs_state_s;

   pfs_state_s           state_reg;
   pfs_state_s           state_next;
   pfs_pkg::pfs_straps_s held;
   logic                 sockb_on;
   logic [1:0]           clk_mode;

   pfs_strap_latch u_straps (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .straps_in  (straps_in),
      .held_out   (held)
   );

   function automatic pfs_pkg::pfs_width_e decode_width(input logic [1:0] code);
      unique case (code)
         pfs_pkg::WID_X8:  decode_width = pfs_pkg::PFS_W8;
         pfs_pkg::WID_X16: decode_width = pfs_pkg::PFS_W16;
         pfs_pkg::WID_X32: decode_width = pfs_pkg::PFS_W32;
         default:          decode_width = pfs_pkg::PFS_WRSVD;
      endcase
   endfunction : decode_width

   // first cycle after reset loads strap decode, then firmware may override
   always_comb begin
      state_next          = state_reg;
      state_next.rst_seen = sys_rst_in;
      if (sys_rst_in) begin
         state_next.width    = pfs_pkg::PFS_W8;
         state_next.steer    = pfs_pkg::STRAP_RST_VAL;
         state_next.rom32_ok = 1'b0;
      end else if (state_reg.rst_seen) begin
         state_next.width    = decode_width({held.width_hi, held.width_lo});
         state_next.steer    = held.boot_steer;
         state_next.rom32_ok = ({held.width_hi, held.width_lo} == pfs_pkg::WID_X32);
      end else begin
         if (fw_width_wr_in) begin
            state_next.width = fw_width_in;
         end
         if (fw_steer_wr_in) begin
            state_next.steer = fw_steer_in;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (clk_en_in) begin
         state_reg <= state_next;
      end
   end

   assign sockb_on = (cfg_idx39_in[pfs_pkg::SOCKB_SEL_LSB +: 2] == pfs_pkg::SOCKB_SEL_ON);
   assign clk_mode = cfg_idx38_in[pfs_pkg::CLKPIN_LSB +: 2];

   always_comb begin
      // socket B card group
      if (sockb_on) begin
         grp_b_pad_out    = {sockb_card_in.ce_low, sockb_card_in.ce_high, 1'b0,
                             sockb_card_in.reg_sel, sockb_card_in.card_reset, 1'b0};
         grp_b_pad_oe_out = 6'h36;                              // ready and wp are inputs
      end else begin
         grp_b_pad_out    = printer_out_in;
         grp_b_pad_oe_out = printer_oe_in;
      end
      // power control groups
      grp_pwr_pad_out[2:0]    = socka_pwr_in;
      grp_pwr_pad_oe_out[2:0] = 3'h7;
      if (!cfg_idx39_in[pfs_pkg::SOCKA_PWR_BIT]) begin
         grp_pwr_pad_out[2:0]    = gpio_out_in[2:0];
         grp_pwr_pad_oe_out[2:0] = gpio_oe_in[2:0];
      end
      grp_pwr_pad_out[5:3]    = sockb_pwr_in;
      grp_pwr_pad_oe_out[5:3] = 3'h7;
      if (!cfg_idx39_in[pfs_pkg::SOCKB_PWR_BIT]) begin
         grp_pwr_pad_out[5:3]    = gpio_out_in[5:3];
         grp_pwr_pad_oe_out[5:3] = gpio_oe_in[5:3];
      end
      // socket A / test port group, ordered ce_low, ce_high, reset, reg_sel
      if (held.test_port) begin
         grp_a_pad_out    = {3'h0, test_data_out_in};
         grp_a_pad_oe_out = 4'h1;
      end else begin
         grp_a_pad_out    = {socka_card_in.ce_low | (state_reg.steer & boot_decode_in),
                             socka_card_in.ce_high | (state_reg.steer & boot_decode_in),
                             socka_card_in.card_reset, socka_card_in.reg_sel};
         grp_a_pad_oe_out = 4'hf;
      end
      // lcd group
      if (cfg_idxdd_in[pfs_pkg::GFX_EN_BIT]) begin
         grp_lcd_pad_out    = lcd_sig_in;
         grp_lcd_pad_oe_out = 14'h3fff;
      end else begin
         grp_lcd_pad_out    = vlbus_out_in;
         grp_lcd_pad_oe_out = vlbus_oe_in;
      end
      // shared clock pin
      clk_pad_out       = 1'b0;
      clk_pad_oe_out    = 1'b0;
      timer_clk_sel_out = 1'b0;
      unique case (clk_mode)
         pfs_pkg::CLKPIN_BURST: begin
            clk_pad_out    = burst_last_in;
            clk_pad_oe_out = 1'b1;
         end
         pfs_pkg::CLKPIN_CLKOUT: begin
            clk_pad_out    = sys_clk_copy_in;
            clk_pad_oe_out = 1'b1;
         end
         pfs_pkg::CLKPIN_TMRIN: begin
            timer_clk_sel_out = 1'b1;
         end
         default: begin
         end
      endcase
   end

   assign timer_clk_out = clk_pad_in & timer_clk_sel_out;
   // test port inputs: tck, tms, tdi, and tdo echo
   assign test_port_out = held.test_port ? {grp_a_pad_in[3:1], test_data_out_in} : 4'h0;

   // boot decode steering
   assign boot_rom_select_out = boot_decode_in & ~state_reg.steer;
   assign socka_boot_sel_out  = boot_decode_in & state_reg.steer;
   assign rom32_buffer_oe_out = state_reg.rom32_ok & rom_select_any_in & rom_is_32_in;
   assign databuf_output_en_out = held.buffer_ctl & databuf_oe_in;
   assign databuf_read_low_out  = held.buffer_ctl & databuf_rdl_in;
   assign databuf_read_high_out = held.buffer_ctl & databuf_rdh_in;
   assign boot_width_out      = state_reg.width;
   assign boot_steer_out      = state_reg.steer;
   assign rom32_allowed_out   = state_reg.rom32_ok;

   a_rom32_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      rom32_buffer_oe_out |-> (held.width_hi && held.width_lo))
      else $error("rom32 buffer enable without x32 strap");
   a_dbuf_gate: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (databuf_output_en_out || databuf_read_low_out || databuf_read_high_out) |-> held.buffer_ctl)
      else $error("bus buffer control without strap");
   a_width_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && state_reg.rst_seen) |=>
      (boot_width_out == decode_width({held.width_hi, held.width_lo})))
      else $error("boot width not from straps");
   a_fw_width: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && !state_reg.rst_seen && fw_width_wr_in) |=>
      (boot_width_out == $past(fw_width_in)))
      else $error("firmware width ignored");
   a_fw_steer: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (clk_en_in && !state_reg.rst_seen && fw_steer_wr_in) |=>
      (boot_steer_out == $past(fw_steer_in)))
      else $error("firmware steering ignored");
   a_steer_excl: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !(boot_rom_select_out && socka_boot_sel_out))
      else $error("boot decode on both targets");
   a_sockb_route: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sockb_on |-> (grp_b_pad_out[5] == sockb_card_in.ce_low && grp_b_pad_oe_out == 6'h36))
      else $error("socket b controls not routed");
   a_test_route: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      held.test_port |-> (grp_a_pad_oe_out == 4'h1 && grp_a_pad_out[0] == test_data_out_in))
      else $error("test port not routed");
   a_lcd_route: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      cfg_idxdd_in[2] |-> (grp_lcd_pad_out == lcd_sig_in))
      else $error("lcd signals not routed");
   a_clk_tmr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (clk_mode == 2'h3) |-> (!clk_pad_oe_out && timer_clk_sel_out))
      else $error("clock pin mode wrong");
endmodule : pfs_pin_mux
`default_nettype wire

/* core/pfs_pkg.sv */
// Purpose: shared constants and carriers for the pin-function select block
// Assumes: config bits arrive as plain ports, no register bus
// Notes: width codes follow the strap encoding, high strap bit first
package pfs_pkg;
   // config index 39h fields
   localparam int SOCKB_SEL_LSB  = 0;
   localparam logic [1:0] SOCKB_SEL_ON = 2'h1;
   localparam int SOCKA_PWR_BIT  = 5;
   localparam int SOCKB_PWR_BIT  = 6;
   // config index ddh field
   localparam int GFX_EN_BIT     = 2;
   // config index 38h field, bits 7-6
   localparam int CLKPIN_LSB     = 6;
   localparam logic [1:0] CLKPIN_BURST  = 2'h1;
   localparam logic [1:0] CLKPIN_CLKOUT = 2'h2;
   localparam logic [1:0] CLKPIN_TMRIN  = 2'h3;
   // width strap codes {hi,lo}
   localparam logic [1:0] WID_X8   = 2'h0;
   localparam logic [1:0] WID_RSVD = 2'h1;
   localparam logic [1:0] WID_X16  = 2'h2;
   localparam logic [1:0] WID_X32  = 2'h3;
   // strap defaults, matching the weak pulldowns
   localparam logic STRAP_RST_VAL = 1'b0;

   typedef enum logic [1:0] {PFS_W8, PFS_W16, PFS_W32, PFS_WRSVD} pfs_width_e;

   typedef struct packed {
      logic       width_hi;
      logic       width_lo;
      logic       boot_steer;
      logic       buffer_ctl;
      logic       test_port;
   } pfs_straps_s;

   typedef struct packed {
      logic       ce_low;
      logic       ce_high;
      logic       ready;
      logic       reg_sel;
      logic       card_reset;
      logic       write_prot;
   } pfs_card_s;

   typedef struct packed {
      logic       supply;
      logic       prog1;
      logic       prog2;
   } pfs_pwr_s;
endpackage : pfs_pkg

/* core/pfs_strap_latch.sv */
// Purpose: capture board straps while reset is held
// Assumes: straps are static during reset, clock runs during reset
// Notes: holds values until the next reset
`timescale 1ns/10ps
`default_nettype none
module pfs_strap_latch (
   input  wire logic               clk_in,
   input  wire logic               sys_rst_in,
   input  wire logic               clk_en_in,
   input  wire pfs_pkg::pfs_straps_s straps_in,
   output var pfs_pkg::pfs_straps_s  held_out
);
   typedef struct packed {
      pfs_pkg::pfs_straps_s straps;
   } pfs_latch_state_s;

   pfs_latch_state_s state_reg;
   pfs_latch_state_s state_next;

   always_comb begin
      state_next = state_reg;
      if (sys_rst_in) begin
         state_next.straps = straps_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (clk_en_in) begin
         state_reg <= state_next;
      end
   end

   assign held_out = state_reg.straps;

   a_straps_frozen: assert property (@(posedge clk_in)
      (clk_en_in && !sys_rst_in && !$past(sys_rst_in)) |=> $stable(held_out))
      else $error("strap copy changed outside reset");
   a_straps_caught: assert property (@(posedge clk_in)
      (clk_en_in && sys_rst_in) |=> (held_out == $past(straps_in)))
      else $error("strap copy missed reset value");
endmodule : pfs_strap_latch
`default_nettype wire
